// *** scu_rx_status.sv ***
`timescale 1ns/1ps
module scu_rx_status (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic card_io,
    input wire logic sync_card,
    input wire logic protocol_t1,
    input wire logic inverse_convention,
    input wire logic card_present,
    input wire logic uart_reset_control,
    input wire logic clk_switch_osc_done,
    input wire logic clk_switch_xtal_done,
    input wire logic tx_mode,
    input wire logic tx_char_written,
    input wire logic tx_char_sent,
    input wire logic tx_parity_ok,
    input wire logic last_character_mode,
    output logic interrupt_out_low_n,
    output logic parity_error_flag,
    output logic receive_full_flag,
    output logic fifo_empty_flag,
    output logic block_guard_flag,
    output logic clock_switch_done,
    output logic card_present_flag,
    output logic tx_empty_rx_full_flag
);
    scu_pkg::scu_rx_state_t rx_state;
    logic io_q;
    logic [15:0] rx_cyc;
    logic [3:0] rx_bit;
    logic [8:0] rx_raw;
    logic rx_start;
    logic rx_done;
    logic [7:0] rx_byte;
    logic rx_par_ok;
    logic [7:0] fifo_mem [scu_pkg::FIFO_DEPTH_MAX];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] fifo_count;
    logic [3:0] next_count;
    logic [3:0] fifo_depth;
    logic [2:0] fifo_len;
    logic [2:0] pe_limit;
    logic [3:0] pe_count;
    logic pe_armed;
    logic [7:0] pe_clr_cnt;
    logic push;
    logic pop;
    logic urr_read;
    logic usr_read;
    logic fcr_write;
    logic pe_set;
    logic [15:0] bgt_cyc;
    logic [4:0] bgt_etu;
    logic bgt_run;
    logic [4:0] bgt_limit;
    logic tx_mode_q;
    logic full_q;

    // convert a framed character to direct convention, flag parity
    function automatic logic [8:0] scu_decode(input logic [8:0] raw, input logic inv);
        logic [8:0] lv;
        logic [7:0] b;
        lv = inv ? ~raw : raw;
        for (int i = 0; i < 8; i++) begin
            b[i] = inv ? lv[7 - i] : lv[i];
        end
        return {~(^lv), b};
    endfunction

    assign {rx_par_ok, rx_byte} = scu_decode(rx_raw, inverse_convention);
    assign urr_read = reg_rd && (reg_addr == scu_pkg::RECEIVE_DATA_ADDR);
    assign usr_read = reg_rd && (reg_addr == scu_pkg::UART_STATUS_ADDR);
    assign fcr_write = reg_wr && (reg_addr == scu_pkg::FIFO_CTRL_ADDR);
    assign fifo_depth = {1'b0, fifo_len} + 4'h1;
    // a T=0 parity failure never enters the fifo; an overflowing byte is lost
    assign push = rx_done && (rx_par_ok || protocol_t1) && (fifo_count < fifo_depth)
                  && !sync_card;
    assign pop = urr_read && (fifo_count != scu_pkg::FIFO_COUNT_EMPTY) && !sync_card;
    assign next_count = fifo_count + {3'h0, push} - {3'h0, pop};
    assign pe_set = rx_done && !rx_par_ok && !sync_card
                    && (protocol_t1 || (pe_armed && pe_count[2:0] == pe_limit));
    assign bgt_limit = protocol_t1 ? scu_pkg::BGT_ETU_T1 : scu_pkg::BGT_ETU_T0;

    // line sampling, inputs already synchronous
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_q <= 1'b1;
        end else begin
            io_q <= card_io;
        end
    end

    // character receiver: mid-bit sampling of start, 8 data and parity
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state <= scu_pkg::SCU_RX_IDLE;
            rx_cyc <= 16'h0000;
            rx_bit <= 4'h0;
            rx_raw <= 9'h000;
            rx_done <= 1'b0;
            rx_start <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_start <= 1'b0;
            case (rx_state)
                scu_pkg::SCU_RX_IDLE: begin
                    if (io_q && !card_io && !sync_card) begin
                        rx_state <= scu_pkg::SCU_RX_START;
                        rx_cyc <= scu_pkg::ETU_HALF_CYCLES;
                        rx_start <= 1'b1;
                    end
                end
                scu_pkg::SCU_RX_START: begin
                    if (rx_cyc != 16'h0000) begin
                        rx_cyc <= rx_cyc - 16'h0001;
                    end else if (!io_q) begin
                        rx_state <= scu_pkg::SCU_RX_BITS;
                        rx_cyc <= scu_pkg::ETU_CYCLES - 16'h0001;
                        rx_bit <= 4'h0;
                    end else begin
                        rx_state <= scu_pkg::SCU_RX_IDLE; // glitch, not a start bit
                    end
                end
                scu_pkg::SCU_RX_BITS: begin
                    if (rx_cyc != 16'h0000) begin
                        rx_cyc <= rx_cyc - 16'h0001;
                    end else begin
                        rx_raw[rx_bit] <= io_q;
                        rx_cyc <= scu_pkg::ETU_CYCLES - 16'h0001;
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == scu_pkg::RX_LAST_BIT) begin
                            rx_state <= scu_pkg::SCU_RX_IDLE;
                            rx_done <= 1'b1;
                        end
                    end
                end
                default: rx_state <= scu_pkg::SCU_RX_IDLE;
            endcase
        end
    end

    // fifo storage, written oldest-first and read in the same order
    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= rx_byte;
        end
    end

    // fifo pointers and occupancy
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            fifo_count <= scu_pkg::FIFO_COUNT_EMPTY;
        end else begin
            // pointers wrap at the programmed depth so entries stay in order
            if (push) begin
                wr_ptr <= (wr_ptr == fifo_len) ? 3'h0 : wr_ptr + 3'h1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == fifo_len) ? 3'h0 : rd_ptr + 3'h1;
            end
            fifo_count <= next_count;
        end
    end

    // fifo flags follow the next occupancy so they never lag the count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_empty_flag <= 1'b1;
            receive_full_flag <= 1'b0;
        end else begin
            fifo_empty_flag <= (next_count == scu_pkg::FIFO_COUNT_EMPTY);
            receive_full_flag <= (next_count >= fifo_depth);
        end
    end

    // fifo control written by software: depth and parity limit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_len <= scu_pkg::FC_RESET;
            pe_limit <= scu_pkg::FC_RESET;
        end else if (fcr_write) begin
            fifo_len <= reg_wdata[scu_pkg::FC_FL_LSB +: 3];
            pe_limit <= reg_wdata[scu_pkg::FC_PEC_LSB +: 3];
        end
    end

    // T=0 error counter; disarmed once the limit hits until software rewrites it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pe_count <= 4'h0;
            pe_armed <= 1'b1;
        end else if (fcr_write) begin
            pe_count <= 4'h0;
            pe_armed <= 1'b1;
        end else if (rx_done && !protocol_t1 && !sync_card && pe_armed) begin
            if (rx_par_ok) begin
                pe_count <= 4'h0;
            end else if (pe_count[2:0] == pe_limit) begin
                pe_armed <= 1'b0;
            end else begin
                pe_count <= pe_count + 4'h1;
            end
        end
    end

    // parity flag with delayed clear after a status read; a new error wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            parity_error_flag <= 1'b0;
            pe_clr_cnt <= 8'h00;
        end else begin
            if (usr_read && parity_error_flag) begin
                pe_clr_cnt <= scu_pkg::PE_CLEAR_CYCLES;
            end else if (pe_clr_cnt != 8'h00) begin
                pe_clr_cnt <= pe_clr_cnt - 8'h01;
            end
            if (pe_set) begin
                parity_error_flag <= 1'b1;
            end else if (pe_clr_cnt == 8'h01) begin
                parity_error_flag <= 1'b0;
            end
        end
    end

    // interrupt: parity error flag (T=0 limit, any T=1 error), or receive buffer full (never before full)
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_out_low_n <= 1'b1;
        end else begin
            interrupt_out_low_n <= !(parity_error_flag || receive_full_flag);
        end
    end

    // block guard counter, restarted by each start bit seen on the line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bgt_cyc <= 16'h0000;
            bgt_etu <= 5'h00;
            bgt_run <= 1'b0;
            block_guard_flag <= 1'b0;
        end else if (rx_start) begin
            bgt_cyc <= 16'h0000;
            bgt_etu <= 5'h00;
            bgt_run <= 1'b1;
            block_guard_flag <= 1'b0;
        end else if (bgt_run) begin
            if (bgt_cyc == scu_pkg::ETU_CYCLES - 16'h0001) begin
                bgt_cyc <= 16'h0000;
                bgt_etu <= bgt_etu + 5'h01;
            end else begin
                bgt_cyc <= bgt_cyc + 16'h0001;
            end
            if (bgt_etu == bgt_limit) begin
                block_guard_flag <= 1'b1;
                bgt_run <= 1'b0;
            end
        end
    end

    // clock switch completion; uart reset control low forces it clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_switch_done <= 1'b0;
        end else if (!uart_reset_control) begin
            clock_switch_done <= 1'b0;
        end else if (clk_switch_osc_done) begin
            clock_switch_done <= 1'b1;
        end else if (clk_switch_xtal_done) begin
            clock_switch_done <= 1'b0;
        end
    end

    // presence contact, registered for a clean status bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            card_present_flag <= 1'b0;
        end else begin
            card_present_flag <= card_present;
        end
    end

    // tx empty / rx full: set events win over software clears
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_empty_rx_full_flag <= 1'b0;
            tx_mode_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            tx_mode_q <= tx_mode;
            full_q <= receive_full_flag;
            if (!uart_reset_control) begin
                tx_empty_rx_full_flag <= 1'b0;
            end else if ((tx_mode && !tx_mode_q)
                         || (tx_char_sent && !(last_character_mode && tx_parity_ok))
                         || (receive_full_flag && !full_q)) begin
                tx_empty_rx_full_flag <= 1'b1;
            end else if (tx_char_written || urr_read || (!tx_mode && tx_mode_q)) begin
                tx_empty_rx_full_flag <= 1'b0;
            end
        end
    end

    // register read port; writes to read-only offsets are ignored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= scu_pkg::RECEIVE_DATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
            case (reg_addr)
                scu_pkg::MIXED_STATUS_ADDR: begin
                    reg_rdata[scu_pkg::MS_CLOCK_SWITCH_DONE_BIT] <= clock_switch_done;
                    reg_rdata[scu_pkg::MS_FE_BIT] <= fifo_empty_flag;
                    reg_rdata[scu_pkg::MS_BGT_BIT] <= block_guard_flag;
                    reg_rdata[scu_pkg::MS_PRES_BIT] <= card_present_flag;
                    reg_rdata[scu_pkg::MS_TBRB_BIT] <= tx_empty_rx_full_flag;
                end
                scu_pkg::RECEIVE_DATA_ADDR: begin
                    if (sync_card) begin
                        reg_rdata[0] <= io_q;
                    end else begin
                        reg_rdata <= fifo_mem[rd_ptr];
                    end
                end
                scu_pkg::UART_STATUS_ADDR: begin
                    reg_rdata[scu_pkg::US_PE_BIT] <= parity_error_flag;
                    reg_rdata[scu_pkg::US_TBRB_BIT] <= tx_empty_rx_full_flag;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    property p_fifo_empty;
        @(posedge clk) disable iff (sys_rst) fifo_empty_flag == (fifo_count == scu_pkg::FIFO_COUNT_EMPTY);
    endproperty
    a_fifo_empty: assert property (p_fifo_empty) else $error("empty flag disagrees with fifo");

    property p_rx_full;
        @(posedge clk) disable iff (sys_rst) receive_full_flag == (fifo_count >= fifo_depth);
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("full flag disagrees with fifo");

    property p_t0_drop;
        @(posedge clk) disable iff (sys_rst)
            (rx_done && !rx_par_ok && !protocol_t1 && !pop) |=> fifo_count == $past(fifo_count);
    endproperty
    a_t0_drop: assert property (p_t0_drop) else $error("T0 parity error byte stored");

    property p_t1_keep;
        @(posedge clk) disable iff (sys_rst)
            (rx_done && !rx_par_ok && protocol_t1 && !sync_card && !pop && fifo_count < fifo_depth)
            |=> (fifo_count == $past(fifo_count) + 4'h1) && parity_error_flag;
    endproperty
    a_t1_keep: assert property (p_t1_keep) else $error("T1 parity error char lost");

    property p_pe_irq;
        @(posedge clk) disable iff (sys_rst) $rose(parity_error_flag) |=> !interrupt_out_low_n;
    endproperty
    a_pe_irq: assert property (p_pe_irq) else $error("interrupt not driven low");

    property p_bgt_expiry;
        @(posedge clk) disable iff (sys_rst) $rose(block_guard_flag) |-> $past(bgt_etu) == bgt_limit;
    endproperty
    a_bgt_expiry: assert property (p_bgt_expiry) else $error("guard flag at wrong count");

    property p_sync_bit;
        @(posedge clk) disable iff (sys_rst)
            (urr_read && sync_card) |=> reg_rdata == {7'h00, $past(io_q)};
    endproperty
    a_sync_bit: assert property (p_sync_bit) else $error("sync card read wrong");

    property p_pe_clear;
        @(posedge clk) disable iff (sys_rst)
            $fell(parity_error_flag) |-> $past(pe_clr_cnt) == 8'h01;
    endproperty
    a_pe_clear: assert property (p_pe_clear) else $error("parity flag cleared early");

    property p_presence;
        @(posedge clk) disable iff (sys_rst) !$past(sys_rst) |-> card_present_flag == $past(card_present);
    endproperty
    a_presence: assert property (p_presence) else $error("presence bit stale");

    property p_riu_clear;
        @(posedge clk) disable iff (sys_rst)
            !uart_reset_control |=> !tx_empty_rx_full_flag && !clock_switch_done;
    endproperty
    a_riu_clear: assert property (p_riu_clear) else $error("reset control did not clear");
endmodule

// *** scu_pkg.sv ***
package scu_pkg;
    // register offsets on the microcontroller data port
    localparam logic [3:0] MIXED_STATUS_ADDR = 4'hc;
    localparam logic [3:0] FIFO_CTRL_ADDR = 4'hc;
    localparam logic [3:0] RECEIVE_DATA_ADDR = 4'hd;
    localparam logic [3:0] UART_STATUS_ADDR = 4'he;
    // mixed status bit positions
    localparam int MS_CLOCK_SWITCH_DONE_BIT = 7;
    localparam int MS_FE_BIT = 6;
    localparam int MS_BGT_BIT = 5;
    localparam int MS_PRES_BIT = 2;
    localparam int MS_TBRB_BIT = 0;
    // uart status bit positions (only the bits kept by this block)
    localparam int US_PE_BIT = 3;
    localparam int US_TBRB_BIT = 0;
    // fifo control field positions
    localparam int FC_PEC_LSB = 4;
    localparam int FC_FL_LSB = 0;
    localparam logic [2:0] FC_RESET = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PE_CLEAR_DELAY_NS = 2000;
    localparam int PE_CLEAR_CYCLES_INT = (PE_CLEAR_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1
                                         : (PE_CLEAR_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [7:0] PE_CLEAR_CYCLES = 8'(PE_CLEAR_CYCLES_INT);
    localparam logic [15:0] ETU_CYCLES = 16'h0174;
    localparam logic [15:0] ETU_HALF_CYCLES = 16'h00ba;
    localparam logic [4:0] BGT_ETU_T1 = 5'h16;
    localparam logic [4:0] BGT_ETU_T0 = 5'h10;
    // character framing: 8 data bits and parity after the start bit
    localparam logic [3:0] RX_LAST_BIT = 4'h8;
    localparam int FIFO_DEPTH_MAX = 8;
    localparam logic [3:0] FIFO_COUNT_EMPTY = 4'h0;
    localparam logic [7:0] RECEIVE_DATA_RESET = 8'h00;
    typedef enum logic [1:0] {
        SCU_RX_IDLE,
        SCU_RX_START,
        SCU_RX_BITS
    } scu_rx_state_t;
endpackage

// *** scu_card_model.sv ***
`timescale 1ns/1ps
module scu_card_model (
    input wire logic clk,
    output logic card_io
);
    localparam int ETU = int'(scu_pkg::ETU_CYCLES);

    // line idles high through the reader's pull-up
    initial card_io = 1'b1;

    // hold one level for whole etus; callers stand on a falling edge
    task automatic hold_bit(input logic level, input int etus);
        card_io = level;
        repeat (etus * ETU) @(negedge clk);
    endtask

    // level for a synchronous card, which has no framing
    task automatic set_level(input logic level);
        card_io = level;
    endtask

    // start, 8 data, even parity, 2 etu guard: 12 etu in all
    task automatic send_char(input logic [7:0] data, input logic inverse, input logic bad_parity);
        logic par;
        par = ^data ^ bad_parity;
        hold_bit(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            hold_bit(inverse ? ~data[7 - i] : data[i], 1);
        end
        hold_bit(inverse ? ~par : par, 1);
        hold_bit(1'b1, 2);
    endtask
endmodule

// *** tb_scu_rx_status.sv ***
`timescale 1ns/1ps
module tb_scu_rx_status;
    localparam int ETU = int'(scu_pkg::ETU_CYCLES);
    logic clk, sys_rst, reg_rd, reg_wr, card_io, sync_card, protocol_t1, inverse_convention, card_present;
    logic uart_reset_control, clk_switch_osc_done, clk_switch_xtal_done, tx_mode, tx_char_written;
    logic tx_char_sent, tx_parity_ok, last_character_mode, interrupt_out_low_n, parity_error_flag;
    logic receive_full_flag, fifo_empty_flag, block_guard_flag, clock_switch_done, card_present_flag;
    logic tx_empty_rx_full_flag;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [7:0] dat [3] = '{8'ha5, 8'h3c, 8'h5a};
    int n_errors = 0;
    int checked = 0;

    scu_rx_status DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .card_io(card_io), .sync_card(sync_card),
        .protocol_t1(protocol_t1), .inverse_convention(inverse_convention), .card_present(card_present),
        .uart_reset_control(uart_reset_control), .clk_switch_osc_done(clk_switch_osc_done),
        .clk_switch_xtal_done(clk_switch_xtal_done), .tx_mode(tx_mode), .tx_char_written(tx_char_written),
        .tx_char_sent(tx_char_sent), .tx_parity_ok(tx_parity_ok), .last_character_mode(last_character_mode),
        .interrupt_out_low_n(interrupt_out_low_n), .parity_error_flag(parity_error_flag),
        .receive_full_flag(receive_full_flag), .fifo_empty_flag(fifo_empty_flag),
        .block_guard_flag(block_guard_flag), .clock_switch_done(clock_switch_done),
        .card_present_flag(card_present_flag), .tx_empty_rx_full_flag(tx_empty_rx_full_flag));
    scu_card_model card (.clk(clk), .card_io(card_io));

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic cf(input string name, input logic exp, input logic got);
        chk(name, {7'h00, exp}, {7'h00, got});
    endtask

    // strobe held one cycle, data sampled a cycle after the taking edge
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        v = reg_rdata;
    endtask

    task automatic rc(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(name, exp, v);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask

    // one-cycle pulses: osc done, xtal done, tx written, tx sent
    task automatic strobe(input logic [3:0] m);
        {clk_switch_osc_done, clk_switch_xtal_done, tx_char_written, tx_char_sent} = m;
        tick(1);
        {clk_switch_osc_done, clk_switch_xtal_done, tx_char_written, tx_char_sent} = 4'h0;
        tick(2);
    endtask

    task automatic endt(input string name);
        $display("test %s done", name);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // about twice the expected run length
    initial begin
        #2_000_000;
        n_errors++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        {reg_addr, reg_rd, reg_wr, reg_wdata, sync_card, protocol_t1, inverse_convention} = '0;
        {clk_switch_osc_done, clk_switch_xtal_done, tx_mode, tx_char_written, tx_char_sent} = '0;
        {card_present, uart_reset_control, tx_parity_ok, last_character_mode} = 4'he;
        tick(2);
        sys_rst = 1'b0;
        tick(2);
        rc("mixed_status", 4'hc, 8'h44);
        card_present = 1'b0;
        tick(2);
        cf("card_present", 1'b0, card_present_flag);
        rc("mixed_status", 4'hc, 8'h40);
        rc("unmapped", 4'h3, 8'h00);
        endt("reset");
        wr(4'hc, 8'h12);
        for (int i = 0; i < 3; i++) begin
            card.send_char(dat[i], 1'b0, 1'b0);
            cf("fifo_empty", 1'b0, fifo_empty_flag);
            cf("receive_full", i == 2, receive_full_flag);
            cf("interrupt_n", i != 2, interrupt_out_low_n);
        end
        cf("tx_empty_rx_full", 1'b1, tx_empty_rx_full_flag);
        rc("receive_data", 4'hd, dat[0]);
        cf("receive_full", 1'b0, receive_full_flag);
        cf("tx_empty_rx_full", 1'b0, tx_empty_rx_full_flag);
        rc("receive_data", 4'hd, dat[1]);
        rc("receive_data", 4'hd, dat[2]);
        cf("fifo_empty", 1'b1, fifo_empty_flag);
        inverse_convention = 1'b1;
        card.send_char(8'h96, 1'b1, 1'b0);
        rc("receive_data", 4'hd, 8'h96);
        inverse_convention = 1'b0;
        endt("fifo");
        wr(4'hc, 8'h10);
        card.send_char(8'h11, 1'b0, 1'b1);
        cf("parity_error", 1'b0, parity_error_flag);
        cf("fifo_empty", 1'b1, fifo_empty_flag);
        card.send_char(8'h22, 1'b0, 1'b1);
        cf("parity_error", 1'b1, parity_error_flag);
        cf("interrupt_n", 1'b0, interrupt_out_low_n);
        rd(4'he, d);
        cf("status_parity", 1'b1, d[3]);
        tick(80);
        cf("parity_error", 1'b1, parity_error_flag);
        tick(40);
        cf("parity_error", 1'b0, parity_error_flag);
        // counting is rearmed only by writing the limit again
        wr(4'hc, 8'h00);
        card.send_char(8'h33, 1'b0, 1'b1);
        cf("parity_error", 1'b1, parity_error_flag);
        endt("parity_t0");
        protocol_t1 = 1'b1;
        card.send_char(8'h44, 1'b0, 1'b1);
        cf("parity_error", 1'b1, parity_error_flag);
        rc("receive_data", 4'hd, 8'h44);
        tick(9 * ETU);
        cf("block_guard", 1'b0, block_guard_flag);
        tick(2 * ETU);
        cf("block_guard", 1'b1, block_guard_flag);
        rc("mixed_status", 4'hc, 8'h60);
        protocol_t1 = 1'b0;
        card.send_char(8'h55, 1'b0, 1'b0);
        tick(3 * ETU);
        cf("block_guard", 1'b0, block_guard_flag);
        tick(2 * ETU);
        cf("block_guard", 1'b1, block_guard_flag);
        rc("receive_data", 4'hd, 8'h55);
        endt("t1_and_guard");
        strobe(4'h8);
        cf("clock_switch", 1'b1, clock_switch_done);
        // power-down may be entered only once the switch reads done
        rd(4'hc, d);
        cf("mixed_clock_switch_done", 1'b1, d[7]);
        strobe(4'h4);
        cf("clock_switch", 1'b0, clock_switch_done);
        strobe(4'h8);
        tx_mode = 1'b1;
        tick(2);
        cf("tx_empty_rx_full", 1'b1, tx_empty_rx_full_flag);
        uart_reset_control = 1'b0;
        tick(2);
        cf("clock_switch", 1'b0, clock_switch_done);
        cf("tx_empty_rx_full", 1'b0, tx_empty_rx_full_flag);
        uart_reset_control = 1'b1;
        tick(1);
        strobe(4'h1);
        cf("tx_empty_rx_full", 1'b1, tx_empty_rx_full_flag);
        strobe(4'h2);
        cf("tx_empty_rx_full", 1'b0, tx_empty_rx_full_flag);
        last_character_mode = 1'b1;
        strobe(4'h1);
        cf("tx_empty_rx_full", 1'b0, tx_empty_rx_full_flag);
        // a naked last character still reports the buffer empty
        tx_parity_ok = 1'b0;
        strobe(4'h1);
        cf("tx_empty_rx_full", 1'b1, tx_empty_rx_full_flag);
        tx_parity_ok = 1'b1;
        last_character_mode = 1'b0;
        strobe(4'h1);
        tx_mode = 1'b0;
        tick(2);
        cf("tx_empty_rx_full", 1'b0, tx_empty_rx_full_flag);
        endt("clock_and_tx");
        sync_card = 1'b1;
        for (int v = 0; v < 2; v++) begin
            card.set_level(v[0]);
            tick(2);
            rd(4'hd, d);
            cf("sync_bit", v[0], d[0]);
        end
        endt("sync_card");
        close_out();
    end
endmodule
